// ---- bench/atcst_host_rx.sv ----
`timescale 1ns/1ps
`default_nettype none
module atcst_host_rx #(
    parameter int unsigned BIT_CYC = 4
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic listen_in,
    input wire logic line_in,
    output logic [6:0] char_out,
    output logic char_valid_out,
    output logic frame_err_out
);
    int unsigned tick_q, bit_q;
    logic busy_q;
    logic [9:0] bits_q, full_w;

    // first bit ends lowest
    assign full_w = {line_in, bits_q[9:1]};

    // sample each bit mid-way
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            busy_q <= 1'b0;
            tick_q <= 0;
            bit_q <= 0;
            bits_q <= 10'h0;
            char_out <= 7'h0;
            char_valid_out <= 1'b0;
            frame_err_out <= 1'b0;
        end
        else
        begin
            char_valid_out <= 1'b0;
            if (!busy_q)
            begin
                busy_q <= listen_in && !line_in;
                tick_q <= BIT_CYC / 2;
                bit_q <= 0;
            end
            else if (tick_q > 1)
                tick_q <= tick_q - 1;
            else
            begin
                bits_q <= full_w;
                tick_q <= BIT_CYC;
                bit_q <= bit_q + 1;
                if (bit_q == 9)
                begin
                    busy_q <= 1'b0;
                    char_valid_out <= 1'b1;
                    char_out <= full_w[7:1];
                    // start low, stop high, even parity
                    frame_err_out <= full_w[0] | !full_w[9] | (^full_w[8:1]);
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/atcst_tx_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "atcst_defines.svh"
module atcst_tx_checker #(
    parameter int unsigned STANDBY_CYC = 20,
    parameter int unsigned DONE_CYC = 10
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire atcst_pkg::atcst_bus_req_t bus_req_in,
    input wire logic [31:0] bus_rdata_out,
    input wire logic sensor_on_in,
    input wire logic other_alarm_in,
    input wire logic [15:0] enc_limit_in,
    input wire logic phase_a_pulse_out,
    input wire logic standby_clear_out,
    input wire logic alarm_out,
    input wire logic multiturn_limit_mismatch_alarm,
    input wire logic enc_limit_wr_out,
    input wire logic [15:0] enc_limit_data_out,
    input wire logic util_done_out
);
    // slack for sync flops and edge detect
    localparam int SB_LO = STANDBY_CYC;
    localparam int SB_HI = STANDBY_CYC + 8;
    int unsigned done_run_d, done_run_q;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    // run length of done
    always_comb done_run_d = util_done_out ? done_run_q + 1 : 0;
    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            done_run_q <= 0;
        else
            done_run_q <= done_run_d;
    end

    standby_time_a: assert property (
        $rose(sensor_on_in) |-> ##[SB_LO:SB_HI] standby_clear_out
    ) else $error("standby late");
    frame_start_a: assert property (
        standby_clear_out |-> ##[1:80] !phase_a_pulse_out
    ) else $error("no start bit");
    util_pair_a: assert property (
        enc_limit_wr_out |-> util_done_out ##1 !enc_limit_wr_out
    ) else $error("write pulse bad");
    wr_cause_a: assert property (
        enc_limit_wr_out |-> $past(bus_req_in.wr) && $past(bus_req_in.wdata[0])
            && $past(bus_req_in.addr) == `ATCST_REG_UTIL
    ) else $error("stray write");
    done_len_a: assert property (
        $fell(util_done_out) |-> done_run_q == DONE_CYC
    ) else $error("done length");
    mm_set_a: assert property (
        multiturn_limit_mismatch_alarm [*2] |-> enc_limit_data_out != enc_limit_in
    ) else $error("false mismatch");
    mm_clr_a: assert property (
        (enc_limit_data_out == enc_limit_in) [*2] |-> !multiturn_limit_mismatch_alarm
    ) else $error("mismatch held");
    alarm_level_a: assert property (
        alarm_out == (multiturn_limit_mismatch_alarm || other_alarm_in)
    ) else $error("alarm level");
    rdata_zero_a: assert property (
        (!$past(bus_req_in.rd) || $past(bus_req_in.addr) == 8'h20) |-> bus_rdata_out == 32'h0
    ) else $error("stray read data");
endmodule

bind atcst_tx atcst_tx_checker #(.STANDBY_CYC(STANDBY_CYC), .DONE_CYC(DONE_CYC)) i_chk (
    .clk_sys_in, .rst_n_in, .bus_req_in, .bus_rdata_out, .sensor_on_in, .other_alarm_in,
    .enc_limit_in, .phase_a_pulse_out, .standby_clear_out, .alarm_out,
    .multiturn_limit_mismatch_alarm, .enc_limit_wr_out, .enc_limit_data_out, .util_done_out
);
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "atcst_defines.svh"
module tb_top;
    localparam int unsigned BIT_CYC = 4;
    localparam int unsigned DONE_CYC = 10;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    atcst_pkg::atcst_bus_req_t bus_req = '0;
    logic sensor_on = 1'b0, motor_on = 1'b0, div_a = 1'b1, abs_enc = 1'b1;
    logic fwd = 1'b0, rev = 1'b0, single = 1'b0, other_alarm = 1'b0;
    logic listen = 1'b1;
    logic [15:0] nv_limit = 16'hffff;
    logic [15:0] enc_limit = 16'hffff;
    logic [31:0] rdata, rd_val;
    logic phase_a, standby_clr, alarm, mismatch, enc_wr, util_done, rx_valid, rx_err;
    logic [15:0] enc_data, limit_set;
    logic [6:0] rx_char;
    logic [6:0] rx_q[$];
    int bad_count = 0, cmp_count = 0;
    int cyc = 0, clr_seen = 0, wr_seen = 0;

    atcst_tx #(.BIT_CYC(BIT_CYC), .STANDBY_CYC(20), .RESUME_CYC(20), .DONE_CYC(DONE_CYC)) i_dut (
        .clk_sys_in, .rst_n_in, .bus_req_in(bus_req),
        .bus_rdata_out(rdata), .sensor_on_in(sensor_on), .motor_power_on_in(motor_on),
        .div_pulse_a_in(div_a), .fwd_rev_in(fwd), .rev_rev_in(rev), .abs_encoder_in(abs_enc),
        .single_turn_in(single), .nv_limit_in(nv_limit), .enc_limit_in(enc_limit),
        .alarm_code_in(12'h3c0), .other_alarm_in(other_alarm), .phase_a_pulse_out(phase_a),
        .standby_clear_out(standby_clr), .alarm_out(alarm),
        .multiturn_limit_mismatch_alarm(mismatch), .enc_limit_wr_out(enc_wr),
        .enc_limit_data_out(enc_data), .multiturn_limit_setting(limit_set),
        .util_done_out(util_done)
    );
    atcst_host_rx #(.BIT_CYC(BIT_CYC)) i_rx (
        .clk_sys_in, .rst_n_in, .listen_in(listen), .line_in(phase_a),
        .char_out(rx_char), .char_valid_out(rx_valid), .frame_err_out(rx_err)
    );

    always #5 clk_sys_in = ~clk_sys_in;

    task automatic conclude();
        $display("cmp %0d bad %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // host side; encoder copy of the limit too
    always @(posedge clk_sys_in)
    begin
        cyc++;
        if (rx_valid)
            rx_q.push_back(rx_char);
        if (rx_valid)
            chk_val({31'h0, rx_err}, 32'h0);
        if (standby_clr)
            clr_seen++;
        if (enc_wr)
            wr_seen++;
        if (enc_wr)
            enc_limit <= enc_data;
        if (cyc == 95000)
        begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    // one bus cycle plus an idle one
    task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        tick(1);
        bus_req <= '0;
        #1 rd_val = rdata;
        tick(1);
    endtask

    task automatic turn(input logic ahead, input int n);
        repeat (n)
        begin
            fwd <= ahead;
            rev <= !ahead;
            tick(1);
            fwd <= 1'b0;
            rev <= 1'b0;
            tick(1);
        end
    endtask

    task automatic expect_frame(input string s);
        int t;
        byte b;
        t = 0;
        while (rx_q.size() < 8 && t < 3000)
        begin
            tick(1);
            t++;
        end
        chk_val(rx_q.size(), 32'h8);
        for (int i = 0; i < rx_q.size(); i++)
        begin
            b = s[i];
            chk_val({25'h0, rx_q[i]}, {25'h0, b[6:0]});
        end
        rx_q.delete();
    endtask

    // sensor-on, frame, post wait, then drop
    task automatic pos_frame(input string s, input logic alarm_drop);
        int k;
        sensor_on <= 1'b1;
        expect_frame(s);
        tick(BIT_CYC);
        bus_op(1'b0, `ATCST_REG_STATUS, 32'h0);
        chk_val({29'h0, rd_val[2:0]}, 32'h4);
        k = 0;
        do
        begin
            bus_op(1'b0, `ATCST_REG_STATUS, 32'h0);
            k++;
        end
        while (rd_val[2:0] !== 3'h0 && k < 30);
        chk_val({29'h0, rd_val[2:0]}, 32'h0);
        motor_on <= !alarm_drop;
        tick(4);
        sensor_on <= 1'b0;
        if (alarm_drop)
            expect_frame("ALM3C0.\r");
        tick(100);
        chk_val(rx_q.size(), 32'h0);
        motor_on <= 1'b0;
        tick(3 * BIT_CYC);
    endtask

    task automatic power_cycle(input logic [15:0] nv, input logic st);
        rst_n_in <= 1'b0;
        nv_limit <= nv;
        single <= st;
        tick(4);
        rst_n_in <= 1'b1;
        tick(3);
    endtask

    task automatic end_test(input string n);
        $display("test %s: %0d cmp %0d bad", n, cmp_count, bad_count);
    endtask

    initial
    begin
        tick(4);
        rst_n_in <= 1'b1;
        tick(2);
        bus_op(1'b0, `ATCST_REG_LIMIT, 32'h0);
        chk_val(rd_val, 32'h0000ffff);
        bus_op(1'b0, `ATCST_REG_WPROT, 32'h0);
        chk_val(rd_val, 32'h0);
        bus_op(1'b0, `ATCST_REG_STATUS, 32'h0);
        chk_val(rd_val, 32'hffff0020);
        bus_op(1'b0, 8'h20, 32'h0);
        chk_val(rd_val, 32'h0);
        end_test("reset");
        // pulses pass through outside frames
        listen <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            div_a <= i[0];
            tick(1);
            #1 chk_val({31'h0, phase_a}, {31'h0, i[0]});
            tick(1);
        end
        div_a <= 1'b1;
        tick(2);
        listen <= 1'b1;
        pos_frame("P+00000\r", 1'b0);
        chk_val(clr_seen, 32'h1);
        end_test("zero");
        // non-default limit, wraps, limit copy
        bus_op(1'b1, `ATCST_REG_LIMIT, 32'h63);
        bus_op(1'b0, `ATCST_REG_LIMIT, 32'h0);
        chk_val(rd_val, 32'h63);
        chk_val({16'h0, limit_set}, 32'h63);
        chk_val({16'h0, enc_data}, 32'hffff);
        power_cycle(16'h63, 1'b0);
        chk_val({16'h0, enc_data}, 32'h63);
        chk_val({30'h0, mismatch, alarm}, 32'h3);
        turn(1'b0, 1);
        bus_op(1'b0, `ATCST_REG_COUNT, 32'h0);
        chk_val(rd_val, 32'h63);
        turn(1'b1, 1);
        bus_op(1'b0, `ATCST_REG_COUNT, 32'h0);
        chk_val(rd_val, 32'h0);
        bus_op(1'b1, `ATCST_REG_WPROT, 32'h1);
        bus_op(1'b1, `ATCST_REG_UTIL, 32'h1);
        tick(2);
        chk_val(wr_seen, 32'h0);
        bus_op(1'b0, `ATCST_REG_UTIL, 32'h0);
        chk_val(rd_val, 32'h2);
        bus_op(1'b1, `ATCST_REG_WPROT, 32'h0);
        bus_op(1'b1, `ATCST_REG_UTIL, 32'h1);
        tick(2);
        chk_val({wr_seen[30:0], util_done}, 32'h3);
        chk_val({30'h0, mismatch, alarm}, 32'h0);
        other_alarm <= 1'b1;
        tick(2);
        chk_val({31'h0, alarm}, 32'h1);
        other_alarm <= 1'b0;
        tick(DONE_CYC);
        chk_val({31'h0, util_done}, 32'h0);
        end_test("limit");
        // default range wraps, alarm frame
        enc_limit <= 16'hffff;
        power_cycle(16'hffff, 1'b0);
        turn(1'b1, 32767);
        pos_frame("P+32767\r", 1'b1);
        turn(1'b1, 1);
        pos_frame("P-32768\r", 1'b0);
        turn(1'b0, 1);
        pos_frame("P+32767\r", 1'b0);
        end_test("wrap");
        power_cycle(16'hffff, 1'b1);
        turn(1'b1, 3);
        pos_frame("P+00000\r", 1'b0);
        end_test("single turn");
        abs_enc <= 1'b0;
        power_cycle(16'h63, 1'b0);
        chk_val({31'h0, mismatch}, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire

// ---- src/atcst_defines.svh ----
`ifndef ATCST_DEFINES_SVH
`define ATCST_DEFINES_SVH

`define ATCST_REG_LIMIT 8'h00
`define ATCST_REG_WPROT 8'h04
`define ATCST_REG_UTIL 8'h08
`define ATCST_REG_STATUS 8'h0c
`define ATCST_REG_COUNT 8'h10
`define ATCST_LIMIT_DEFAULT 16'hffff
`define ATCST_WPROT_RESET 4'h0
`define ATCST_WPROT_LOCKED 4'h1
`define ATCST_CLK_HZ 100000000
`define ATCST_BAUD 9600
`define ATCST_STANDBY_MS 100
`define ATCST_RESUME_MS 400
`define ATCST_DONE_MS 1000
`define ATCST_CHARS 8
`define ATCST_DIGITS 5
`define ATCST_BIT_START 4'h0
`define ATCST_BIT_PARITY 4'h8
`define ATCST_BIT_STOP 4'h9
`define ATCST_CH_P 7'h50
`define ATCST_CH_PLUS 7'h2b
`define ATCST_CH_MINUS 7'h2d
`define ATCST_CH_ZERO 7'h30
`define ATCST_CH_CR 7'h0d
`define ATCST_CH_A 7'h41
`define ATCST_CH_L 7'h4c
`define ATCST_CH_M 7'h4d
`define ATCST_CH_DOT 7'h2e
`define ATCST_CH_HEX_A 7'h37

`endif

// ---- src/atcst_pkg.sv ----
package atcst_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_CONV,
        ST_SEND,
        ST_POST
    } atcst_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } atcst_bus_req_t;

endpackage

// ---- src/atcst_tx.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "atcst_defines.svh"

// What this block does
// RQ1: frame goes out on the phase-A line.
// RQ2: start, 7 bits, even parity, stop; 9600 bps; 8 chars.
// RQ3: frame is P, sign, five digits, CR.
// RQ4: zero count sends five zeros.
// RQ5: default limit: -32768 to +32767, wrapping.
// RQ6: initial pulses use the division path.
// RQ7: sensor-on fall sends alarm contents.
// RQ8: sensor-on fall ignored under motor power.
// RQ9: limit 0 to 65535, default 65535, absolute only.
// RQ10: other limit: reverse at zero loads limit.
// RQ11: other limit: forward at limit gives zero.
// RQ12: limit is wanted count minus one.
// RQ13: limit unlike encoder raises mismatch.
// RQ14: alarm output high under mismatch.
// RQ15: limit copy shows done; refused under protect 0001.
// RQ16: new limit applies after power cycle.
// RQ17: single-turn reports zero.
// RQ18: standby and clear 100 ms after sensor-on.
// RQ19: pulses resume 400 ms after last char; the code passes them from the last stop bit on.
// RQ20: data bits lsb first.
module atcst_tx #(
    parameter int unsigned BIT_CYC = (`ATCST_CLK_HZ + `ATCST_BAUD / 2) / `ATCST_BAUD,
    parameter int unsigned STANDBY_CYC = `ATCST_CLK_HZ / 1000 * `ATCST_STANDBY_MS,
    parameter int unsigned RESUME_CYC = `ATCST_CLK_HZ / 1000 * `ATCST_RESUME_MS,
    parameter int unsigned DONE_CYC = `ATCST_CLK_HZ / 1000 * `ATCST_DONE_MS
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire atcst_pkg::atcst_bus_req_t bus_req_in,
    output logic [31:0] bus_rdata_out,
    input wire logic sensor_on_in,
    input wire logic motor_power_on_in,
    input wire logic div_pulse_a_in,
    input wire logic fwd_rev_in,
    input wire logic rev_rev_in,
    input wire logic abs_encoder_in,
    input wire logic single_turn_in,
    input wire logic [15:0] nv_limit_in,
    input wire logic [15:0] enc_limit_in,
    input wire logic [11:0] alarm_code_in,
    input wire logic other_alarm_in,
    output logic phase_a_pulse_out,
    output logic standby_clear_out,
    output logic alarm_out,
    output logic multiturn_limit_mismatch_alarm,
    output logic enc_limit_wr_out,
    output logic [15:0] enc_limit_data_out,
    output logic [15:0] multiturn_limit_setting,
    output logic util_done_out
);

    // hex digit to ascii
    function automatic logic [6:0] hex_char(input logic [3:0] nib);
        hex_char = (nib < 4'ha) ? (`ATCST_CH_ZERO + {3'h0, nib}) : (`ATCST_CH_HEX_A + {3'h0, nib});
    endfunction

    // decimal weight, digit 0 first
    function automatic logic [16:0] pow10(input logic [2:0] idx);
        case (idx)
            3'h0: pow10 = 17'h02710;
            3'h1: pow10 = 17'h003e8;
            3'h2: pow10 = 17'h00064;
            3'h3: pow10 = 17'h0000a;
            default: pow10 = 17'h00001;
        endcase
    endfunction

    // line level for one bit slot
    function automatic logic frame_bit(input logic [6:0] ch, input logic [3:0] slot);
        case (slot)
            `ATCST_BIT_START: frame_bit = 1'b0;
            `ATCST_BIT_PARITY: frame_bit = ^ch;
            `ATCST_BIT_STOP: frame_bit = 1'b1;
            default: frame_bit = ch[slot[2:0] - 3'h1];
        endcase
    endfunction

    // pin synchronisers
    logic sens_meta_q, sens_sync_q, sens_prev_q;
    logic pwr_meta_q, pwr_sync_q;

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sens_meta_q <= 1'b0;
            sens_sync_q <= 1'b0;
            sens_prev_q <= 1'b0;
            pwr_meta_q <= 1'b0;
            pwr_sync_q <= 1'b0;
        end
        else
        begin
            sens_meta_q <= sensor_on_in;
            sens_sync_q <= sens_meta_q;
            sens_prev_q <= sens_sync_q;
            pwr_meta_q <= motor_power_on_in;
            pwr_sync_q <= pwr_meta_q;
        end
    end

    wire sens_rise = sens_sync_q & ~sens_prev_q;
    wire sens_fall = ~sens_sync_q & sens_prev_q;

    // configuration, straps and the revolution counter
    logic init_q, init_d;
    logic abs_q, abs_d;
    logic st_q, st_d;
    logic [15:0] act_limit_q, act_limit_d;
    logic [15:0] set_limit_q, set_limit_d;
    logic [3:0] wprot_q, wprot_d;
    logic [15:0] cnt_q, cnt_d;
    logic refused_q, refused_d;
    logic wr_pulse_q, wr_pulse_d;
    logic [31:0] done_tmr_q, done_tmr_d;
    logic [31:0] rdata_q, rdata_d;
    atcst_pkg::atcst_state_t state_q, state_d;
    logic mismatch;
    logic default_lim;

    assign default_lim = (act_limit_q == `ATCST_LIMIT_DEFAULT);
    assign mismatch = abs_q & (act_limit_q != enc_limit_in); // [RQ13]

    always_comb
    begin
        init_d = 1'b1;
        abs_d = abs_q;
        st_d = st_q;
        act_limit_d = act_limit_q;
        set_limit_d = set_limit_q;
        wprot_d = wprot_q;
        cnt_d = cnt_q;
        refused_d = refused_q;
        wr_pulse_d = 1'b0;
        done_tmr_d = done_tmr_q;
        rdata_d = 32'h0;
        // straps and limit caught once after reset (power-up)
        if (!init_q)
        begin
            abs_d = abs_encoder_in;
            st_d = single_turn_in;
            act_limit_d = nv_limit_in; // [RQ16]
        end
        // revolution count; both steps at once cancel out
        if (st_q)
        begin
            cnt_d = 16'h0; // [RQ17]
        end
        else if (fwd_rev_in & ~rev_rev_in)
        begin
            if (!default_lim && cnt_q == act_limit_q)
            begin
                cnt_d = 16'h0; // [RQ11]
            end
            else
            begin
                cnt_d = cnt_q + 16'h1; // [RQ5]
            end
        end
        else if (rev_rev_in & ~fwd_rev_in)
        begin
            if (!default_lim && cnt_q == 16'h0)
            begin
                cnt_d = act_limit_q; // [RQ10]
            end
            else
            begin
                cnt_d = cnt_q - 16'h1; // [RQ5]
            end
        end
        // writes; a new limit reaches only the nv store
        if (bus_req_in.wr)
        begin
            case (bus_req_in.addr)
                `ATCST_REG_LIMIT: set_limit_d = bus_req_in.wdata[15:0]; // [RQ9] [RQ16]
                `ATCST_REG_WPROT: wprot_d = bus_req_in.wdata[3:0];
                `ATCST_REG_UTIL:
                begin
                    if (bus_req_in.wdata[0])
                    begin
                        if (wprot_q == `ATCST_WPROT_LOCKED)
                        begin
                            refused_d = 1'b1; // [RQ15]
                        end
                        else
                        begin
                            refused_d = 1'b0;
                            wr_pulse_d = 1'b1; // [RQ15]
                            done_tmr_d = DONE_CYC;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (done_tmr_q != 32'h0 && !wr_pulse_d)
        begin
            done_tmr_d = done_tmr_q - 32'h1; // [RQ15]
        end
        // register reads, answered in the next cycle
        if (bus_req_in.rd)
        begin
            case (bus_req_in.addr)
                `ATCST_REG_LIMIT: rdata_d = {16'h0, set_limit_q};
                `ATCST_REG_WPROT: rdata_d = {28'h0, wprot_q};
                `ATCST_REG_UTIL: rdata_d = {30'h0, refused_q, done_tmr_q != 32'h0};
                `ATCST_REG_STATUS: rdata_d = {act_limit_q, 9'h0, st_q, abs_q, mismatch, 1'b0, state_q};
                `ATCST_REG_COUNT: rdata_d = {16'h0, cnt_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            init_q <= 1'b0;
            abs_q <= 1'b0;
            st_q <= 1'b0;
            act_limit_q <= `ATCST_LIMIT_DEFAULT;
            set_limit_q <= `ATCST_LIMIT_DEFAULT;
            wprot_q <= `ATCST_WPROT_RESET;
            cnt_q <= 16'h0;
            refused_q <= 1'b0;
            wr_pulse_q <= 1'b0;
            done_tmr_q <= 32'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            init_q <= init_d;
            abs_q <= abs_d;
            st_q <= st_d;
            act_limit_q <= act_limit_d;
            set_limit_q <= set_limit_d;
            wprot_q <= wprot_d;
            cnt_q <= cnt_d;
            refused_q <= refused_d;
            wr_pulse_q <= wr_pulse_d;
            done_tmr_q <= done_tmr_d;
            rdata_q <= rdata_d;
        end
    end

    // frame sequencer
    logic [6:0] chars_q [`ATCST_CHARS];
    logic [6:0] chars_d [`ATCST_CHARS];
    logic [31:0] tmr_q, tmr_d;
    logic [16:0] mag_q, mag_d;
    logic [2:0] dig_q, dig_d;
    logic [3:0] acc_q, acc_d;
    logic [2:0] ci_q, ci_d;
    logic [3:0] slot_q, slot_d;
    logic is_alarm_q, is_alarm_d;
    logic line_q, line_d;
    logic clr_q, clr_d;

    always_comb
    begin
        state_d = state_q;
        chars_d = chars_q;
        tmr_d = tmr_q;
        mag_d = mag_q;
        dig_d = dig_q;
        acc_d = acc_q;
        ci_d = ci_q;
        slot_d = slot_q;
        is_alarm_d = is_alarm_q;
        clr_d = 1'b0;
        // outside a frame the line carries the divided pulses
        line_d = div_pulse_a_in; // [RQ1] [RQ6]
        case (state_q)
            atcst_pkg::ST_IDLE:
            begin
                if (abs_q && sens_rise)
                begin
                    state_d = atcst_pkg::ST_WAIT;
                    tmr_d = 32'h0;
                end
                else if (abs_q && sens_fall && !pwr_sync_q) // [RQ7] [RQ8]
                begin
                    chars_d[0] = `ATCST_CH_A;
                    chars_d[1] = `ATCST_CH_L;
                    chars_d[2] = `ATCST_CH_M;
                    chars_d[3] = hex_char(alarm_code_in[11:8]);
                    chars_d[4] = hex_char(alarm_code_in[7:4]);
                    chars_d[5] = hex_char(alarm_code_in[3:0]);
                    chars_d[6] = `ATCST_CH_DOT;
                    chars_d[7] = `ATCST_CH_CR;
                    is_alarm_d = 1'b1;
                    ci_d = 3'h0;
                    slot_d = 4'h0;
                    tmr_d = 32'h0;
                    state_d = atcst_pkg::ST_SEND;
                end
            end
            atcst_pkg::ST_WAIT:
            begin
                if (tmr_q == STANDBY_CYC - 1)
                begin
                    clr_d = 1'b1; // [RQ18]
                    chars_d[0] = `ATCST_CH_P; // [RQ3]
                    chars_d[7] = `ATCST_CH_CR;
                    // signed view only with the default limit; zero always takes '+'
                    if (default_lim && cnt_q[15])
                    begin
                        chars_d[1] = `ATCST_CH_MINUS;
                        mag_d = 17'h0 - {cnt_q[15], cnt_q};
                    end
                    else
                    begin
                        chars_d[1] = `ATCST_CH_PLUS; // [RQ4]
                        mag_d = {1'b0, cnt_q};
                    end
                    dig_d = 3'h0;
                    acc_d = 4'h0;
                    is_alarm_d = 1'b0;
                    state_d = atcst_pkg::ST_CONV;
                end
                else
                begin
                    tmr_d = tmr_q + 32'h1; // [RQ18]
                end
            end
            atcst_pkg::ST_CONV:
            begin
                // repeated subtraction, at most nine steps per digit
                if (mag_q >= pow10(dig_q))
                begin
                    mag_d = mag_q - pow10(dig_q);
                    acc_d = acc_q + 4'h1;
                end
                else
                begin
                    chars_d[dig_q + 3'h2] = `ATCST_CH_ZERO + {3'h0, acc_q}; // [RQ3] [RQ4]
                    acc_d = 4'h0;
                    dig_d = dig_q + 3'h1;
                    if (dig_q == 3'(`ATCST_DIGITS - 1))
                    begin
                        ci_d = 3'h0;
                        slot_d = 4'h0;
                        tmr_d = 32'h0;
                        state_d = atcst_pkg::ST_SEND;
                    end
                end
            end
            atcst_pkg::ST_SEND:
            begin
                line_d = frame_bit(chars_q[ci_q], slot_q); // [RQ1] [RQ2] [RQ20]
                if (tmr_q == BIT_CYC - 1)
                begin
                    tmr_d = 32'h0;
                    if (slot_q == `ATCST_BIT_STOP)
                    begin
                        slot_d = 4'h0;
                        ci_d = ci_q + 3'h1;
                        if (ci_q == 3'(`ATCST_CHARS - 1)) // [RQ2]
                        begin
                            state_d = is_alarm_q ? atcst_pkg::ST_IDLE : atcst_pkg::ST_POST;
                        end
                    end
                    else
                    begin
                        slot_d = slot_q + 4'h1;
                    end
                end
                else
                begin
                    tmr_d = tmr_q + 32'h1;
                end
            end
            atcst_pkg::ST_POST:
            begin
                // initial incremental pulses follow on the same divided path
                if (tmr_q == RESUME_CYC - 1)
                begin
                    state_d = atcst_pkg::ST_IDLE; // [RQ19]
                end
                else
                begin
                    tmr_d = tmr_q + 32'h1; // [RQ19]
                end
            end
            default: state_d = atcst_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q <= atcst_pkg::ST_IDLE;
            for (int i = 0; i < `ATCST_CHARS; i++)
            begin
                chars_q[i] <= 7'h0;
            end
            tmr_q <= 32'h0;
            mag_q <= 17'h0;
            dig_q <= 3'h0;
            acc_q <= 4'h0;
            ci_q <= 3'h0;
            slot_q <= 4'h0;
            is_alarm_q <= 1'b0;
            line_q <= 1'b1;
            clr_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            chars_q <= chars_d;
            tmr_q <= tmr_d;
            mag_q <= mag_d;
            dig_q <= dig_d;
            acc_q <= acc_d;
            ci_q <= ci_d;
            slot_q <= slot_d;
            is_alarm_q <= is_alarm_d;
            line_q <= line_d;
            clr_q <= clr_d;
        end
    end

    // outputs
    assign phase_a_pulse_out = line_q;
    assign standby_clear_out = clr_q;
    assign multiturn_limit_mismatch_alarm = mismatch;
    assign alarm_out = mismatch | other_alarm_in; // [RQ14]
    assign enc_limit_wr_out = wr_pulse_q;
    assign enc_limit_data_out = act_limit_q; // [RQ15]
    assign multiturn_limit_setting = set_limit_q;
    assign util_done_out = (done_tmr_q != 32'h0); // [RQ15]
    assign bus_rdata_out = rdata_q;

endmodule
`default_nettype wire
